// *** tb/gsc_checker_assertions.sv ***
`timescale 1ns/100ps
module gsc_checker (
    input wire        core_clk,
    input wire        rst_b,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        sleep_mode,
    input wire        irq,
    input wire        wake_req
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire req = wb_cyc_i && wb_stb_i;
    reg  unmap_r;
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            unmap_r <= 1'b0;
        else
            unmap_r <= req && !wb_we_i && (wb_adr_i[7:2] > 6'h06);
    end
AST_ACK_NEXT: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
AST_DAT_BYTE: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data above byte");
AST_UNMAPPED: assert property (wb_ack_o && unmap_r |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
AST_IRQ_HOLD: assert property (irq && !wb_cyc_i |=> irq)
        else $error("irq fell without access");
AST_IRQ_FALL: assert property ($fell(irq) |-> wb_ack_o)
        else $error("irq fell outside access");
AST_WAKE: assert property (wake_req |-> irq && sleep_mode)
        else $error("wake without sleep or irq");
AST_WAKE_HOLD: assert property (wake_req && !wb_cyc_i |=> wake_req || !sleep_mode)
        else $error("wake dropped while asleep");
    cover property (wake_req);
    cover property ($rose(irq));
    cover property (wb_ack_o && unmap_r);
endmodule // gsc_checker

bind gsc_top gsc_checker chk_u (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_adr_i  (wb_adr_i),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o),
    .sleep_mode(sleep_mode),
    .irq       (irq),
    .wake_req  (wake_req)
);

// *** tb/gsc_ext_model.sv ***
`timescale 1ns/100ps
module gsc_ext_model (
    input  wire crystal_out_pin,
    output reg  crystal_in_pin = 1'b0,
    output reg  ext_clk_pin = 1'b0
);
    // Crystal as a delay in the amplifier loop; swings only while driven
    always @(crystal_out_pin) begin
        crystal_in_pin <= #230 crystal_out_pin;
    end
    // Phase unrelated to the core clock on purpose
    task ext_pulse(input integer n);
        repeat (n) begin
            #330 ext_clk_pin = 1'b1;
            #330 ext_clk_pin = 1'b0;
        end
    endtask
endmodule // gsc_ext_model

// *** tb/tb.sv ***
`timescale 1ns/100ps
module tb;
    reg         core_clk = 1'b0;
    reg         rst_b = 1'b0;
    reg         wb_cyc_i = 1'b0;
    reg         wb_stb_i = 1'b0;
    reg         wb_we_i = 1'b0;
    reg  [7:0]  wb_adr_i = 8'h00;
    reg  [31:0] wb_dat_i = 32'h0;
    reg         gate_pin = 1'b0;
    reg         wrap = 1'b0;
    reg         cmp1 = 1'b0;
    reg         cmp2 = 1'b0;
    reg         lfint_tick = 1'b0;
    reg         sleep_mode = 1'b0;
    reg         xcount = 1'b0;
    reg  [7:0]  q;
    reg  [15:0] v;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o;
    wire        crystal_out_pin;
    wire        crystal_in_pin;
    wire        ext_clk_pin;
    wire        irq;
    wire        wake_req;
    integer     err_total = 0;
    integer     n_compared = 0;
    integer     seed = 40;
    integer     xedges = 0;
    integer     p, t, e, s, pl, lv, x;

    always #50 core_clk = ~core_clk;

    gsc_top dut_u (
        .core_clk                 (core_clk),
        .rst_b                    (rst_b),
        .wb_cyc_i                 (wb_cyc_i),
        .wb_stb_i                 (wb_stb_i),
        .wb_we_i                  (wb_we_i),
        .wb_adr_i                 (wb_adr_i),
        .wb_sel_i                 (4'hf),
        .wb_dat_i                 (wb_dat_i),
        .wb_dat_o                 (wb_dat_o),
        .wb_ack_o                 (wb_ack_o),
        .ext_clk_pin              (ext_clk_pin),
        .crystal_in_pin           (crystal_in_pin),
        .crystal_out_pin          (crystal_out_pin),
        .gate_pin                 (gate_pin),
        .companion_timer_wrap     (wrap),
        .comparator_one_synced_out(cmp1),
        .comparator_two_synced_out(cmp2),
        .lfint_tick               (lfint_tick),
        .sleep_mode               (sleep_mode),
        .irq                      (irq),
        .wake_req                 (wake_req)
    );

    gsc_ext_model pm_u (
        .crystal_out_pin(crystal_out_pin),
        .crystal_in_pin (crystal_in_pin),
        .ext_clk_pin    (ext_clk_pin)
    );

    always @(posedge crystal_in_pin) if (xcount) xedges = xedges + 1;

    task chk(input string nm, input [15:0] got, input [15:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task summarize;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task wb(input w, input [7:0] a, input [7:0] d);
        integer n;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        n = 0;
        @(posedge core_clk);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            n = n + 1;
            @(posedge core_clk);
        end
        if (n == 50) chk("ack", 0, 1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task rdc;
        wb(1'b0, 8'h00, 8'h00);
        v[7:0] = q;
        wb(1'b0, 8'h04, 8'h00);
        v[15:8] = q;
    endtask

    // Counter writes only while no tick is in flight
    task setc(input [15:0] c);
        wb(1'b1, 8'h00, c[7:0]);
        wb(1'b1, 8'h04, c[15:8]);
    endtask

    task tick(input integer n);
        repeat (n) begin
            @(posedge core_clk) lfint_tick <= 1'b1;
            @(posedge core_clk) lfint_tick <= 1'b0;
        end
        repeat (5) @(posedge core_clk);
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        for (x = 2; x < 8; x = x + 1) begin
            wb(1'b0, {x[5:0], 2'b00}, 8'h00);
            chk("reset value", q, 0);
        end
        wb(1'b1, 8'h1c, 8'hff);
        wb(1'b0, 8'h1c, 8'h00);
        chk("unmapped", q, 0);
        wb(1'b1, 8'h08, 8'h36);
        wb(1'b0, 8'h08, 8'h00);
        chk("cc readback", q, 8'h34);
        wb(1'b1, 8'h0c, 8'hff);
        wb(1'b0, 8'h0c, 8'h00);
        chk("gc readback", q & 8'hfb, 8'hc3);
        wb(1'b1, 8'h0c, 8'h00);
        for (p = 0; p < 4; p = p + 1) begin
            wb(1'b1, 8'h08, 8'hc1 | {p[1:0], 4'h0});
            setc(16'h0000);
            t = 8 + ($random(seed) & 31);
            tick(t);
            rdc;
            chk("prescale", v, t >> p);
            wb(1'b1, 8'h08, 8'hc0 | {p[1:0], 4'h0});
            tick(3);
            rdc;
            chk("off holds", v, t >> p);
        end
        wb(1'b1, 8'h08, 8'hc1);
        for (x = 0; x < 32; x = x + 1) begin
            e = x[4];
            s = x[3:2];
            pl = x[1];
            lv = x[0];
            gate_pin <= (s == 0) ? lv[0] : !lv[0];
            wrap <= (s == 1) ? lv[0] : !lv[0];
            cmp1 <= (s == 2) ? lv[0] : !lv[0];
            cmp2 <= (s == 3) ? lv[0] : !lv[0];
            wb(1'b1, 8'h0c, {e[0], pl[0], 4'h0, s[1:0]});
            setc(16'h0000);
            repeat (6) @(posedge core_clk);
            tick(4);
            rdc;
            chk("gate", v, (e == 0 || lv == pl) ? 4 : 0);
        end
        wb(1'b1, 8'h08, 8'h00);
        wb(1'b1, 8'h0c, 8'h00);
        setc(16'h0000);
        wb(1'b1, 8'h08, 8'h81);
        pm_u.ext_pulse(5);
        repeat (8) @(posedge core_clk);
        rdc;
        chk("sync ext", v, 5);
        @(posedge core_clk) sleep_mode <= 1'b1;
        pm_u.ext_pulse(3);
        repeat (8) @(posedge core_clk);
        @(posedge core_clk) sleep_mode <= 1'b0;
        rdc;
        chk("sync sleep holds", v, 5);
        wb(1'b1, 8'h08, 8'h00);
        wb(1'b0, 8'h14, 8'h00);
        setc(16'hffff);
        wb(1'b1, 8'h18, 8'h01);
        wb(1'b1, 8'h08, 8'h85);
        @(posedge core_clk) sleep_mode <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("no wake", wake_req, 0);
        pm_u.ext_pulse(1);
        repeat (8) @(posedge core_clk);
        chk("wake", {wake_req, irq}, 2'b11);
        @(posedge core_clk) sleep_mode <= 1'b0;
        rdc;
        chk("wrapped", v, 0);
        wb(1'b0, 8'h14, 8'h00);
        chk("status", q, 8'h01);
        chk("irq cleared", irq, 0);
        wb(1'b1, 8'h18, 8'h04);
        xcount = 1'b1;
        wb(1'b1, 8'h08, 8'h08);
        wb(1'b0, 8'h10, 8'h00);
        chk("not ready", q, 0);
        x = 0;
        while (irq !== 1'b1 && x < 30000) begin
            x = x + 1;
            @(posedge core_clk);
        end
        chk("osc cycles", xedges >= 1024 && xedges <= 1026, 1);
        wb(1'b0, 8'h10, 8'h00);
        chk("ready", q, 8'h80);
        wb(1'b0, 8'h14, 8'h00);
        chk("osc status", q, 8'h04);
        wb(1'b1, 8'h08, 8'h88);
        setc(16'h0000);
        e = xedges;
        wb(1'b1, 8'h08, 8'h89);
        repeat (200) @(posedge core_clk);
        wb(1'b1, 8'h08, 8'h88);
        e = xedges - e;
        rdc;
        chk("crystal count", v + 1 >= e && v <= e + 1, 1);
        summarize;
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        err_total = err_total + 1;
        summarize;
    end
endmodule // tb

// *** verilog/gsc_defines.vh ***
`ifndef GSC_DEFINES_VH
`define GSC_DEFINES_VH

// Register word indexes; byte address is four times the index
`define GSC_IDX_COUNT_LOW      6'h00
`define GSC_IDX_COUNT_HIGH     6'h01
`define GSC_IDX_COUNTER_CTRL   6'h02
`define GSC_IDX_GATE_CTRL      6'h03
`define GSC_IDX_OSC_STATE      6'h04
`define GSC_IDX_IRQ_STATUS     6'h05
`define GSC_IDX_IRQ_MASK       6'h06

// counter_control fields
`define GSC_CC_SRC_HI          7
`define GSC_CC_SRC_LO          6
`define GSC_CC_PRE_HI          5
`define GSC_CC_PRE_LO          4
`define GSC_CC_OSC_EN          3
`define GSC_CC_SYNC_BYP        2
`define GSC_CC_ON              0
`define GSC_CC_WMASK           8'hfd

// gate_control fields
`define GSC_GC_EN              7
`define GSC_GC_POL             6
`define GSC_GC_VAL             2
`define GSC_GC_SRC_HI          1
`define GSC_GC_SRC_LO          0
`define GSC_GC_WMASK           8'hc3

// oscillator_state_reg fields
`define GSC_OS_READY           7

// Interrupt status and mask layout
`define GSC_IRQ_OVF            0
`define GSC_IRQ_GATE           1
`define GSC_IRQ_OSC            2
`define GSC_IRQ_BITS           3

// Clock source codes
`define GSC_SRC_INSTR          2'b00
`define GSC_SRC_SYS            2'b01
`define GSC_SRC_EXT            2'b10
`define GSC_SRC_LFINT          2'b11

// Gate source codes
`define GSC_GS_PIN             2'b00
`define GSC_GS_WRAP            2'b01
`define GSC_GS_CMP1            2'b10
`define GSC_GS_CMP2            2'b11

// Reset values
`define GSC_RST_COUNT          16'h0000
`define GSC_RST_CC             8'h00
`define GSC_RST_GC             8'h00
`define GSC_RST_MASK           3'h0

// Timing counts
`define GSC_OSC_READY_CYCLES   11'd1024
`define GSC_INSTR_DIV          2'd3

`endif

// *** verilog/gsc_sync.v ***
`timescale 1ns/100ps

// Two-stage synchroniser; only the second stage leaves this module
module gsc_sync #(
    parameter WIDTH = 3
) (
    input  wire             core_clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule // gsc_sync

// *** verilog/gsc_top.v ***
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "gsc_defines.vh"

module gsc_top (
    input  wire        core_clk,
    input  wire        rst_b,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    input  wire        ext_clk_pin,
    input  wire        crystal_in_pin,
    output wire        crystal_out_pin,
    input  wire        gate_pin,
    input  wire        companion_timer_wrap,
    input  wire        comparator_one_synced_out,
    input  wire        comparator_two_synced_out,
    input  wire        lfint_tick,
    input  wire        sleep_mode,
    output wire        irq,
    output wire        wake_req
);

    localparam [2:0] OSC_OFF   = 3'b001;
    localparam [2:0] OSC_WAIT  = 3'b010;
    localparam [2:0] OSC_READY = 3'b100;

    wire [2:0]  pin_sync;
    reg  [15:0] count_r;
    reg  [7:0]  cc_r;
    reg  [7:0]  gc_r;
    reg  [2:0]  pre_r;
    reg  [1:0]  instr_r;
    reg         ext_d1_r;
    reg         ext_d2_r;
    reg         xin_d1_r;
    reg         xout_r;
    reg  [2:0]  osc_state_r;
    reg  [10:0] osc_cnt_r;
    reg         gate_lvl_r;
    reg         gate_open_r;
    reg  [`GSC_IRQ_BITS-1:0] irq_stat_r;
    reg  [`GSC_IRQ_BITS-1:0] irq_mask_r;
    reg  [`GSC_IRQ_BITS-1:0] irq_set;
    reg         ack_r;
    reg  [7:0]  rdata_r;
    reg  [7:0]  rdata_nxt;
    reg         src_tick;
    reg         gate_raw;
    reg  [2:0]  pre_mask;
    reg  [2:0]  osc_state_nxt;

    wire        ext_s;
    wire        gate_s;
    wire        xin_s;
    wire        bus_req;
    wire [5:0]  idx;
    wire        wr_lane;
    wire        wr_low;
    wire        wr_high;
    wire        wr_count;
    wire        rd_stat;
    wire        osc_en;
    wire        sync_byp;
    wire [1:0]  src_sel;
    wire        ext_edge_async;
    wire        ext_edge_sync;
    wire        xin_edge;
    wire        ext_source_edge;
    wire        run_ok;
    wire        gate_open;
    wire        count_en;
    wire        pre_hit;
    wire        inc;
    wire        wrap;
    wire        osc_ready;
    wire        osc_en_rise;

    // Pins from outside the clock domain
    gsc_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in ({crystal_in_pin, gate_pin, ext_clk_pin}),
        .sync_out (pin_sync)
    );

    assign ext_s  = pin_sync[0];
    assign gate_s = pin_sync[1];
    assign xin_s  = pin_sync[2];

    // Wishbone decode
    assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_r;
    assign idx      = wb_adr_i[7:2];
    assign wr_lane  = bus_req & wb_we_i & wb_sel_i[0];
    assign wr_low   = wr_lane & (idx == `GSC_IDX_COUNT_LOW);
    assign wr_high  = wr_lane & (idx == `GSC_IDX_COUNT_HIGH);
    assign wr_count = wr_low | wr_high;
    assign rd_stat  = bus_req & ~wb_we_i & (idx == `GSC_IDX_IRQ_STATUS);

    assign osc_en   = cc_r[`GSC_CC_OSC_EN];
    assign sync_byp = cc_r[`GSC_CC_SYNC_BYP];
    assign src_sel  = cc_r[`GSC_CC_SRC_HI:`GSC_CC_SRC_LO];

    // Edge detection after the synchroniser
    assign ext_edge_async = ext_s & ~ext_d1_r;
    // Extra stage aligns the edge with the internal phase
    assign ext_edge_sync  = ext_d1_r & ~ext_d2_r;
    assign xin_edge       = xin_s & ~xin_d1_r;
    // Crystal replaces the pin clock when the oscillator runs
    assign ext_source_edge = osc_en ? xin_edge :
                             (sync_byp ? ext_edge_async : ext_edge_sync);

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_d1_r <= 1'b0;
            ext_d2_r <= 1'b0;
            xin_d1_r <= 1'b0;
            xout_r   <= 1'b0;
            instr_r  <= 2'd0;
        end else begin
            ext_d1_r <= ext_s;
            ext_d2_r <= ext_d1_r;
            xin_d1_r <= xin_s;
            // Amplifier output; not stopped by sleep
            xout_r   <= osc_en & ~xin_s;
            instr_r  <= instr_r + 2'd1;
        end
    end

    assign crystal_out_pin = xout_r;

    // Count source select; switching modes can lose or add one edge
    always @* begin
        case (src_sel)
            `GSC_SRC_INSTR: src_tick = (instr_r == `GSC_INSTR_DIV);
            `GSC_SRC_SYS:   src_tick = 1'b1;
            `GSC_SRC_EXT:   src_tick = ext_source_edge;
            default:        src_tick = lfint_tick;
        endcase
    end

    // Only external counting with sync_byp set, pin or crystal, survives sleep
    assign run_ok = ~sleep_mode |
                    ((src_sel == `GSC_SRC_EXT) & sync_byp);

    // Gate source mux
    always @* begin
        case (gc_r[`GSC_GC_SRC_HI:`GSC_GC_SRC_LO])
            `GSC_GS_PIN:  gate_raw = gate_s;
            `GSC_GS_WRAP: gate_raw = companion_timer_wrap;
            `GSC_GS_CMP1: gate_raw = comparator_one_synced_out;
            default:      gate_raw = comparator_two_synced_out;
        endcase
    end

    assign gate_open = ~gc_r[`GSC_GC_EN] |
                       (gate_lvl_r == gc_r[`GSC_GC_POL]);

    assign count_en = cc_r[`GSC_CC_ON] & run_ok & gate_open &
                      src_tick;

    // Prescale mask: select 0..3 needs 0..3 low bits all ones
    always @* begin
        case (cc_r[`GSC_CC_PRE_HI:`GSC_CC_PRE_LO])
            2'b00:   pre_mask = 3'b000;
            2'b01:   pre_mask = 3'b001;
            2'b10:   pre_mask = 3'b011;
            default: pre_mask = 3'b111;
        endcase
    end

    assign pre_hit = ((pre_r & pre_mask) == pre_mask);
    assign inc     = count_en & pre_hit;
    assign wrap    = inc & (count_r == 16'hffff);

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_r <= 3'd0;
        end else if (wr_count) begin
            pre_r <= 3'd0;
        end else if (count_en) begin
            pre_r <= pre_r + 3'd1;
        end
    end

    // Write wins over a same-cycle increment
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= `GSC_RST_COUNT;
        end else if (wr_low) begin
            count_r[7:0] <= wb_dat_i[7:0];
        end else if (wr_high) begin
            count_r[15:8] <= wb_dat_i[7:0];
        end else if (inc) begin
            count_r <= count_r + 16'h0001;
        end
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_lvl_r  <= 1'b0;
            gate_open_r <= 1'b1;
        end else begin
            gate_lvl_r  <= gate_raw;
            gate_open_r <= gate_open;
        end
    end

    // Oscillator start-up tracker
    assign osc_en_rise = wr_lane & (idx == `GSC_IDX_COUNTER_CTRL) &
                         wb_dat_i[`GSC_CC_OSC_EN] & ~osc_en;

    always @* begin
        case (osc_state_r)
            OSC_OFF:   osc_state_nxt = osc_en ? OSC_WAIT : OSC_OFF;
            OSC_WAIT: begin
                if (!osc_en) begin
                    osc_state_nxt = OSC_OFF;
                end else if (xin_edge &&
                    osc_cnt_r == `GSC_OSC_READY_CYCLES - 11'd1) begin
                    osc_state_nxt = OSC_READY;
                end else begin
                    osc_state_nxt = OSC_WAIT;
                end
            end
            OSC_READY: osc_state_nxt = osc_en ? OSC_READY : OSC_OFF;
            default:   osc_state_nxt = OSC_OFF;
        endcase
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_state_r <= OSC_OFF;
            osc_cnt_r   <= 11'd0;
        end else if (osc_en_rise) begin
            osc_state_r <= OSC_WAIT;
            osc_cnt_r   <= 11'd0;
        end else begin
            osc_state_r <= osc_state_nxt;
            if (osc_state_r != OSC_WAIT) begin
                osc_cnt_r <= 11'd0;
            end else if (xin_edge) begin
                osc_cnt_r <= osc_cnt_r + 11'd1;
            end
        end
    end

    assign osc_ready = (osc_state_r == OSC_READY);

    // Control registers
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cc_r       <= `GSC_RST_CC;
            gc_r       <= `GSC_RST_GC;
            irq_mask_r <= `GSC_RST_MASK;
        end else if (wr_lane) begin
            case (idx)
                `GSC_IDX_COUNTER_CTRL:
                    cc_r <= wb_dat_i[7:0] & `GSC_CC_WMASK;
                `GSC_IDX_GATE_CTRL:
                    gc_r <= wb_dat_i[7:0] & `GSC_GC_WMASK;
                `GSC_IDX_IRQ_MASK:
                    irq_mask_r <= wb_dat_i[`GSC_IRQ_BITS-1:0];
                default: ;
            endcase
        end
    end

    // Sticky events; a set in the read cycle survives the clear
    always @* begin
        irq_set = {`GSC_IRQ_BITS{1'b0}};
        irq_set[`GSC_IRQ_OVF]  = wrap;
        irq_set[`GSC_IRQ_GATE] = gc_r[`GSC_GC_EN] & gate_open_r &
                                 ~gate_open;
        irq_set[`GSC_IRQ_OSC]  = (osc_state_r == OSC_WAIT) &
                                 (osc_state_nxt == OSC_READY);
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_r <= {`GSC_IRQ_BITS{1'b0}};
        end else if (rd_stat) begin
            irq_stat_r <= irq_set;
        end else begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    assign irq      = |(irq_stat_r & irq_mask_r);
    // Overflow wakes the core only while it sleeps
    assign wake_req = sleep_mode & irq_stat_r[`GSC_IRQ_OVF] &
                      irq_mask_r[`GSC_IRQ_OVF];

    // Read mux; count is already in this domain so bytes are stable
    always @* begin
        case (idx)
            `GSC_IDX_COUNT_LOW:    rdata_nxt = count_r[7:0];
            `GSC_IDX_COUNT_HIGH:   rdata_nxt = count_r[15:8];
            `GSC_IDX_COUNTER_CTRL: rdata_nxt = cc_r;
            `GSC_IDX_GATE_CTRL: begin
                rdata_nxt = gc_r;
                rdata_nxt[`GSC_GC_VAL] = gate_lvl_r;
            end
            `GSC_IDX_OSC_STATE: begin
                rdata_nxt = 8'h00;
                rdata_nxt[`GSC_OS_READY] = osc_ready;
            end
            `GSC_IDX_IRQ_STATUS:
                rdata_nxt = {5'h00, irq_stat_r};
            `GSC_IDX_IRQ_MASK:
                rdata_nxt = {5'h00, irq_mask_r};
            default:               rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r   <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ack_r <= bus_req;
            if (bus_req && !wb_we_i) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = {24'h000000, rdata_r};

endmodule // gsc_top
